// *** rtl/sdci_pkg.sv ***
package sdci_pkg;
	// ---------------------------------------------------------------
	// Word layout
	// ---------------------------------------------------------------
	localparam int WORD_BITS = 24;
	localparam int CTRL_BITS = 8;
	localparam int DATA_BITS = 16;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;
	localparam int BIT_D8 = 8;
	localparam int BIT_D7 = 7;
	localparam int BIT_D9 = 9;
	localparam int BIT_SEL = 0;
	// ---------------------------------------------------------------
	// Commands
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_LOAD = 8'h01;
	localparam logic [7:0] CMD_CLEAR = 8'h02;
	localparam logic [7:0] CMD_POWER = 8'h03;
	localparam logic [7:0] CMD_LIN = 8'h05;
	localparam logic [3:0] OP_WRITE = 4'h1;
	localparam logic [3:0] OP_WTHRU = 4'h3;
	// ---------------------------------------------------------------
	// Reset values and data masks
	// ---------------------------------------------------------------
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID = 16'h8000;
	localparam logic [15:0] LOW12_MASK = 16'hfff0;
	localparam logic [15:0] FULL_MASK = 16'hffff;
endpackage : sdci_pkg

// *** rtl/sdci_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdci_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// Both stages reset to the pin's idle level, so no false edge follows reset.
			meta <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule : sdci_sync
`default_nettype wire

// *** rtl/sdci_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Sample data on serial clock falling edge
// - Word is 8 control plus 16 data
// - Act on command after 24th bit
// - Frame select low delimits each word
// - Serial clock may idle either level
// - Ignore clocks after a full word
// - Reset code zero or midscale by select
// - Load pin or command copies input register
// - Load command copies only when D8 set
// - Power command sets power-down, done enable
// - Write loads input register only
// - Writethrough loads input and output registers
// - Narrow variant ignores four low bits
// - Output code is straight unipolar binary
// - Clear command acts as power-on reset
// - Short frame is discarded
// - Word-done low after 24 clocks, until frame ends
module sdci_top
	import sdci_pkg::*;
#(
	parameter int RES_BITS = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic frame_n,
	input wire logic sdin,
	input wire logic load_output_n,
	input wire logic midscale_sel,
	output logic word_done_n,
	output logic [15:0] output_code,
	output logic [15:0] input_code,
	output logic power_down,
	output logic linearity
);
	if (RES_BITS != 16 && RES_BITS != 12) begin : g_bad_res
		$error("RES_BITS must be 16 or 12");
	end

	localparam logic [15:0] DATA_MASK = (RES_BITS == 12) ? LOW12_MASK : FULL_MASK;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Idle levels of serial clock, frame select, data and load pin, in port order.
	localparam logic [3:0] PIN_IDLE = 4'h5;
	logic [3:0] pins;
	logic sclk_s, frame_n_s, sdin_s, load_n_s;
	sdci_sync #(.WIDTH(4), .RST_VAL(PIN_IDLE)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({sclk, frame_n, sdin, load_output_n}),
		.q(pins)
	);
	assign {sclk_s, frame_n_s, sdin_s, load_n_s} = pins;

	// ---------------------------------------------------------------
	// Serial state and data registers
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SDCI_IDLE = 3'b001,
		SDCI_SHIFT = 3'b010,
		SDCI_DONE = 3'b100
	} sdci_state_t;

	sdci_state_t state, next_state;
	logic sclk_d, frame_d, next_sclk_d, next_frame_d;
	logic [WORD_BITS-2:0] shreg, next_shreg;
	logic [CNT_W-1:0] count, next_count;
	logic [15:0] next_output_code, next_input_code;
	logic next_power_down, next_linearity, next_word_done_n;
	logic done_en, next_done_en;
	logic rst_pending, next_rst_pending;

	function automatic logic [15:0] reset_code(input logic mid);
		reset_code = mid ? CODE_MID : CODE_ZERO;
	endfunction : reset_code

	logic sclk_fall, frame_fall, frame_rise;
	logic [WORD_BITS-1:0] word;
	logic [7:0] ctrl;
	logic [15:0] data;
	assign sclk_fall = sclk_d & ~sclk_s;
	assign frame_fall = frame_d & ~frame_n_s;
	assign frame_rise = ~frame_d & frame_n_s;
	assign word = {shreg, sdin_s};
	assign ctrl = word[WORD_BITS-1 -: CTRL_BITS];
	assign data = word[DATA_BITS-1:0];

	always_comb begin
		next_sclk_d = sclk_s;
		next_frame_d = frame_n_s;
		next_state = state;
		next_shreg = shreg;
		next_count = count;
		next_output_code = output_code;
		next_input_code = input_code;
		next_power_down = power_down;
		next_linearity = linearity;
		next_done_en = done_en;
		next_word_done_n = word_done_n;
		next_rst_pending = 1'b0;
		if (rst_pending) begin
			// Straps are caught one cycle after reset, never inside the reset itself.
			next_output_code = reset_code(midscale_sel);
		end
		case (state)
			SDCI_IDLE: begin
				if (frame_fall) begin
					next_state = SDCI_SHIFT;
					next_count = '0;
				end
			end
			SDCI_SHIFT: begin
				if (frame_n_s) begin
					next_state = SDCI_IDLE;
				end else if (sclk_fall) begin
					next_shreg = {shreg[WORD_BITS-3:0], sdin_s};
					next_count = count + 5'h01;
					if (count == LAST_BIT) begin
						next_state = SDCI_DONE;
						next_word_done_n = ~done_en;
						if (ctrl == CMD_LOAD) begin
							if (data[BIT_D8]) begin
								next_output_code = input_code;
							end
						end else if (ctrl == CMD_CLEAR) begin
							next_input_code = CODE_ZERO;
							next_output_code = reset_code(midscale_sel);
							next_power_down = 1'b0;
							next_linearity = 1'b0;
							next_done_en = 1'b1;
						end else if (ctrl == CMD_POWER) begin
							next_power_down = data[BIT_D8];
							next_done_en = data[BIT_D7];
							next_word_done_n = ~data[BIT_D7];
						end else if (ctrl == CMD_LIN) begin
							next_linearity = data[BIT_D9];
						end else if (ctrl[7:4] == OP_WRITE && ctrl[BIT_SEL]) begin
							next_input_code = data & DATA_MASK;
						end else if (ctrl[7:4] == OP_WTHRU && ctrl[BIT_SEL]) begin
							next_input_code = data & DATA_MASK;
							next_output_code = data & DATA_MASK;
						end
						// Any other code falls through untouched.
					end
				end
			end
			SDCI_DONE: begin
				if (frame_n_s) begin
					next_state = SDCI_IDLE;
				end
			end
			default: next_state = SDCI_IDLE;
		endcase
		if (frame_n_s) begin
			next_word_done_n = 1'b1;
		end
		if (!load_n_s && !rst_pending) begin
			// Level-sensitive load: a later write this cycle is followed next cycle.
			next_output_code = input_code;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= SDCI_IDLE;
			sclk_d <= 1'b0;
			frame_d <= 1'b1;
			shreg <= '0;
			count <= '0;
			output_code <= CODE_ZERO;
			input_code <= CODE_ZERO;
			power_down <= 1'b0;
			linearity <= 1'b0;
			done_en <= 1'b1;
			word_done_n <= 1'b1;
			rst_pending <= 1'b1;
		end else begin
			state <= next_state;
			sclk_d <= next_sclk_d;
			frame_d <= next_frame_d;
			shreg <= next_shreg;
			count <= next_count;
			output_code <= next_output_code;
			input_code <= next_input_code;
			power_down <= next_power_down;
			linearity <= next_linearity;
			done_en <= next_done_en;
			word_done_n <= next_word_done_n;
			rst_pending <= next_rst_pending;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_done_high_idle: assert property (@(posedge clk) disable iff (sys_rst)
		frame_n_s |=> word_done_n) else $error("word done low outside frame");
	a_short_frame: assert property (@(posedge clk) disable iff (sys_rst)
		(state == SDCI_SHIFT && frame_n_s) |=> $stable(input_code))
		else $error("short frame changed input register");
	a_wthru_out: assert property (@(posedge clk) disable iff (sys_rst)
		(state == SDCI_SHIFT && !frame_n_s && sclk_fall && count == LAST_BIT
		&& ctrl[7:4] == OP_WTHRU && ctrl[BIT_SEL] && load_n_s)
		|=> output_code == $past(data & DATA_MASK)) else $error("writethrough missed");
	a_write_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(state == SDCI_SHIFT && !frame_n_s && sclk_fall && count == LAST_BIT
		&& ctrl[7:4] == OP_WRITE && load_n_s && !rst_pending)
		|=> $stable(output_code)) else $error("write changed output");
	a_done_stays: assert property (@(posedge clk) disable iff (sys_rst)
		(state == SDCI_DONE && !frame_n_s) |=> state == SDCI_DONE)
		else $error("left done state inside frame");
	a_load_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(!load_n_s && !rst_pending) ##1 !load_n_s |=> output_code == $past(input_code))
		else $error("output not following input");
	a_narrow_bits: assert property (@(posedge clk) disable iff (sys_rst)
		RES_BITS == 12 |-> input_code[3:0] == 4'h0) else $error("low bits kept");
	a_strap_code: assert property (@(posedge clk) disable iff (sys_rst)
		rst_pending && load_n_s |=> output_code == reset_code($past(midscale_sel)))
		else $error("reset code wrong");
endmodule : sdci_top
`default_nettype wire

// *** verif/sdci_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdci_host (
	input wire logic clk,
	input wire logic word_done_n,
	output logic sclk,
	output logic frame_n,
	output logic sdin,
	output logic done_seen
);
	logic idle = 1'b0;
	initial begin
		sclk = 1'b0;
		frame_n = 1'b1;
		sdin = 1'b1;
		done_seen = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic send(input logic [47:0] w, input int n);
		frame_n = 1'b0;
		tick(4);
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			sdin = w[47-i];
			tick(4);
			sclk = 1'b0;
			tick(4);
		end
		tick(6);
		done_seen = word_done_n;
		frame_n = 1'b1;
		// Released data shows the inverse so a stale bit is never reused.
		sdin = ~sdin;
		idle = ~idle;
		sclk = idle;
		tick(8);
	endtask : send
endmodule : sdci_host
`default_nettype wire

// *** verif/serial_dac_command_interface_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_dac_command_interface_test;
	import sdci_pkg::*;
	logic clk, sys_rst, sclk, frame_n, sdin, load_output_n, midscale_sel;
	logic word_done_n, power_down, linearity, done_seen;
	logic [15:0] output_code, input_code;
	logic [15:0] narrow_in, narrow_out;
	int err_count = 0;
	int n_checks = 0;
	int cycles = 0;
	sdci_top #(.RES_BITS(16)) DUT (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
		.frame_n(frame_n), .sdin(sdin), .load_output_n(load_output_n),
		.midscale_sel(midscale_sel), .word_done_n(word_done_n),
		.output_code(output_code), .input_code(input_code),
		.power_down(power_down), .linearity(linearity));
	sdci_host host (.clk(clk), .word_done_n(word_done_n), .sclk(sclk),
		.frame_n(frame_n), .sdin(sdin), .done_seen(done_seen));
	sdci_top #(.RES_BITS(12)) DUT12 (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
		.frame_n(frame_n), .sdin(sdin), .load_output_n(load_output_n),
		.midscale_sel(midscale_sel), .word_done_n(),
		.output_code(narrow_out), .input_code(narrow_in),
		.power_down(), .linearity());
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t code %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t flag %b want %b", $time, got, exp);
		end
	endtask : chkb
	task automatic snd(input logic [23:0] w, input int n);
		host.send({w, ~w}, n);
	endtask : snd
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask : fin
	// ----------------
	// Test sequence
	// ----------------
	initial begin
		sys_rst = 1'b1;
		load_output_n = 1'b1;
		midscale_sel = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		chk(output_code, CODE_MID);
		chk(input_code, CODE_ZERO);
		fin("reset");
		snd(24'h111234, 24);
		chk(input_code, 16'h1234);
		chk(output_code, CODE_MID);
		chk(narrow_in, 16'h1230);
		chkb(done_seen, 1'b0);
		chkb(word_done_n, 1'b1);
		snd(24'h10ffff, 24);
		chk(input_code, 16'h1234);
		snd(24'h0100ff, 24);
		chk(output_code, CODE_MID);
		snd(24'h010100, 24);
		chk(output_code, 16'h1234);
		fin("write_load");
		snd(24'h31abcd, 24);
		chk(output_code, 16'habcd);
		chk(narrow_out, 16'habc0);
		snd(24'h315555, 20);
		chk(input_code, 16'habcd);
		chkb(done_seen, 1'b1);
		host.send({24'h110f0f, 24'h319999}, 48);
		chk(input_code, 16'h0f0f);
		chk(output_code, 16'habcd);
		fin("frames");
		load_output_n = 1'b0;
		repeat (4) @(negedge clk);
		chk(output_code, 16'h0f0f);
		snd(24'h117777, 24);
		chk(output_code, 16'h7777);
		load_output_n = 1'b1;
		fin("load_pin");
		snd(24'h030100, 24);
		chkb(power_down, 1'b1);
		chkb(done_seen, 1'b1);
		snd(24'h030080, 24);
		chkb(power_down, 1'b0);
		chkb(done_seen, 1'b0);
		snd(24'h050200, 24);
		chkb(linearity, 1'b1);
		snd(24'h40ffff, 24);
		chk(input_code, 16'h7777);
		chk(output_code, 16'h7777);
		midscale_sel = 1'b0;
		snd(24'h020000, 24);
		chk(output_code, CODE_ZERO);
		chk(input_code, CODE_ZERO);
		chkb(linearity, 1'b0);
		fin("commands");
		report_and_stop();
	end
endmodule : serial_dac_command_interface_test
`default_nettype wire
